// File: tb_tpv_trap_unit.sv
// self-checking bench of the trap priority and vector unit
`timescale 1ns/1ps
`default_nettype none
module tb_tpv_trap_unit;
  logic clk_i, rst_i, ce_i, cyc, stb, we, unlock, mmu, pvalid;
  logic [31:0] adr, dat, pinfo, dinfo, ainfo, base, wb_dat_o;
  logic [3:0] sel;
  logic [17:0] oreq, yreq;
  logic [4:0] areq;
  logic sreq, ireq, sst, sirq, wb_ack_o, from_old, irq_take;
  tpv_pkg::tpv_sync_t so, sy;
  tpv_pkg::tpv_async_t sa;
  tpv_pkg::tpv_win_t trap_o;
  logic [45:0] exp_q[$];
  logic [31:0] rd_q[$];
  logic ce_d;
  logic [45:0] last;
  wire logic [45:0] got = {trap_o, from_old, irq_take};
  int n_errors, checks, seed, i, k;

  tpv_src_model src (.clk_i(clk_i), .rst_i(rst_i), .old_req_i(oreq),
    .young_req_i(yreq), .async_req_i(areq), .store_req_i(sreq),
    .irq_req_i(ireq), .sync_old_o(so), .sync_young_o(sy), .async_o(sa),
    .store_err_o(sst), .irq_o(sirq));
  tpv_trap_unit dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .init_end_unlock_i(unlock), .mmu_enable_i(mmu),
    .sync_old_i(so), .sync_young_i(sy), .async_i(sa),
    .store_bus_err_i(sst), .irq_req_i(sirq), .prog_err_valid_i(pvalid),
    .prog_err_info_i(pinfo), .dsync_info_i(dinfo), .dasync_info_i(ainfo),
    .trap_o(trap_o), .trap_from_old_o(from_old), .irq_take_o(irq_take));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic end_sim();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [45:0] g, input logic [45:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic tend(input string s);
    $display("test %s finished", s);
  endtask : tend

  task automatic wb(input logic w, input logic [15:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {16'h0000, a};
    dat <= d;
    sel <= s;
    for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++) @(posedge clk_i);
    if (n == 20) begin
      n_errors++;
      end_sim();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    wb(1'b0, a, 32'h0000_0000, 4'h0);
  endtask : rd

  function automatic logic [2:0] clsof(input logic [5:0] p);
    if (p <= 6'h05) return 3'h3;
    if (p == 6'h09 || p == 6'h0a || p == 6'h11) return 3'h0;
    if (p < 6'h0e) return 3'h1;
    if (p == 6'h0e) return 3'h4;
    return 3'h5;
  endfunction : clsof

  function automatic logic [45:0] ref_exp(input logic [17:0] o, y,
    input logic [4:0] a, input logic s, q);
    tpv_pkg::tpv_win_t w;
    logic [17:0] v;
    logic fo;
    w = '0;
    fo = 1'b0;
    v = mmu ? o : o & ~18'h00600;
    a[1] = a[1] | s;
    if (a != 5'h00) begin
      for (int j = 4; j >= 0; j--) if (a[j]) w.prio = 6'(j + 1);
      w.async = 1'b1;
      w.cls = a[0] ? 3'h7 : 3'h4;
    end else begin
      fo = v != 18'h0;
      if (!fo) v = mmu ? y : y & ~18'h00600;
      for (int j = 17; j >= 0; j--) if (v[j]) w.prio = 6'(j + 15);
      w.cls = clsof(w.prio - 6'h0f);
      w.debug = w.prio == 6'h20;
    end
    w.valid = w.prio != 6'h00;
    w.vector = base | {24'h000000, w.cls, 5'h00};
    return {w, fo, q && !w.valid};
  endfunction : ref_exp

  task automatic trap(input logic [17:0] o, y, input logic [4:0] a,
                      input logic s, q);
    logic [45:0] e;
    @(posedge clk_i);
    e = ref_exp(o, y, a, s, q);
    oreq <= o;
    yreq <= y;
    areq <= a;
    sreq <= s;
    ireq <= q;
    if (e[45] || e[0]) exp_q.push_back(e);
  endtask : trap

  // results are matched against the oldest note as they appear
  always @(posedge clk_i) begin
    if (!rst_i && wb_ack_o === 1'b1 && we === 1'b0 && rd_q.size() > 0)
      chk({14'h0, wb_dat_o}, {14'h0, rd_q.pop_front()});
    // outputs hold while the enable was low at the last edge
    if (!rst_i && ce_d === 1'b0) begin
      chk(got, last);
    end else if (!rst_i &&
                 (trap_o.valid === 1'b1 || irq_take === 1'b1)) begin
      if (exp_q.size() == 0) chk(got, 46'h0);
      else if (exp_q[0][0]) chk({got[45], got[0]}, 46'h1);
      else chk(got, exp_q[0]);
      if (exp_q.size() > 0) void'(exp_q.pop_front());
    end
    ce_d <= ce_i;
    last <= got;
  end

  initial begin
    {cyc, stb, we, unlock, mmu, pvalid, sreq, ireq} = 8'h00;
    {adr, dat, pinfo, dinfo, ainfo, base} = '0;
    {sel, oreq, yreq, areq} = '0;
    seed = 7;
    n_errors = 0;
    checks = 0;
    ce_i = 1'b1;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(16'h9400, 32'h0);
    rd(16'h9010, 32'h0);
    rd(16'h9018, 32'h0);
    rd(16'h9200, 32'h0);
    wb(1'b1, 16'h9300, 32'hffff_ffff, 4'hf);
    rd(16'h9300, 32'h0);
    tend("reset");
    wb(1'b1, 16'h9400, 32'h0000_1000, 4'hf);
    rd(16'h9400, 32'h0);
    unlock <= 1'b1;
    wb(1'b1, 16'h9400, 32'h0000_2301, 4'hf);
    rd(16'h9400, 32'h0000_2300);
    wb(1'b1, 16'h9400, 32'hffff_55ff, 4'h2);
    rd(16'h9400, 32'h0000_5500);
    wb(1'b1, 16'h9400, 32'h8000_0401, 4'hf);
    base = 32'h8000_0400;
    unlock <= 1'b0;
    dinfo <= $random(seed);
    ainfo <= $random(seed);
    mmu <= 1'b1;
    rd(16'h9400, base);
    tend("vector base");
    for (i = 0; i < 18; i++) trap(18'h1 << i, 18'h0, 5'h0, 0, 0);
    for (i = 0; i < 5; i++) trap(18'h0, 18'h0, 5'h1 << i, 0, 0);
    trap(18'h0, 18'h0, 5'h0, 1, 0);
    trap(18'h20000, 18'h00001, 5'h0, 0, 1);
    trap(18'h0, 18'h00008, 5'h0, 0, 1);
    trap(18'h0, 18'h0, 5'h0, 0, 1);
    trap(18'h00001, 18'h0, 5'h10, 0, 1);
    trap(18'h18000, 18'h0, 5'h0, 0, 0);
    trap(18'h00080, 18'h0, 5'h0, 0, 0);
    trap(18'h0, 18'h0, 5'h0, 0, 0);
    @(posedge clk_i);
    ce_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    ce_i <= 1'b1;
    tend("directed");
    for (k = 0; k < 2; k++) begin
      repeat (3) trap(18'h0, 18'h0, 5'h0, 0, 0);
      mmu <= k[0];
      repeat (3) trap(18'h0, 18'h0, 5'h0, 0, 0);
      trap(18'h00600, 18'h0, 5'h0, 0, 0);
      trap(18'h00600, 18'h00004, 5'h0, 0, 0);
      for (i = 0; i < 40; i++)
        trap(18'($random(seed) & $random(seed)), 18'($random(seed)),
             5'($random(seed) & $random(seed) & $random(seed)),
             1'($random(seed) & $random(seed)), 1'($random(seed)));
    end
    trap(18'h0, 18'h0, 5'h0, 0, 0);
    for (i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge clk_i);
    if (exp_q.size() > 0) begin
      n_errors++;
      end_sim();
    end
    tend("random");
    wb(1'b1, 16'h9010, ~dinfo, 4'hf);
    rd(16'h9010, dinfo);
    rd(16'h9018, ainfo);
    @(posedge clk_i);
    pinfo <= $random(seed);
    pvalid <= 1'b1;
    @(posedge clk_i);
    pvalid <= 1'b0;
    rd(16'h9200, pinfo);
    repeat (3) @(posedge clk_i);
    tend("info");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(16'h9400, 32'h0);
    rd(16'h9200, 32'h0);
    repeat (3) @(posedge clk_i);
    tend("mid reset");
    end_sim();
  end
endmodule : tb_tpv_trap_unit
`default_nettype wire

// File: tpv_pkg.sv
// package: constants, types and helpers of the trap priority and vector unit
package tpv_pkg;

  // register byte offsets on the wishbone slave
  localparam logic [15:0] OFF_DSYNC_INFO  = 16'h9010;
  localparam logic [15:0] OFF_DASYNC_INFO = 16'h9018;
  localparam logic [15:0] OFF_PSYNC_INFO  = 16'h9200;
  localparam logic [15:0] OFF_VEC_BASE    = 16'h9400;

  // reset values
  localparam logic [31:0] VEC_BASE_RST    = 32'h0000_0000;
  localparam logic [31:0] INFO_RST        = 32'h0000_0000;

  // field layout of the vector base register and vector formation
  localparam int unsigned VEC_BASE_RES_BIT = 0;
  localparam int unsigned CLASS_SHIFT      = 5;
  localparam int unsigned CLASS_W          = 3;
  localparam int unsigned NUM_CLASSES      = 8;
  localparam int unsigned VEC_ENTRY_BYTES  = 32;
  localparam int unsigned TABLE_ALIGN      = NUM_CLASSES * VEC_ENTRY_BYTES;

  // pending set sizes and priority numbering
  localparam int unsigned NSYNC   = 18;
  localparam int unsigned NASYNC  = 5;
  localparam int unsigned PRIO_W  = 6;
  localparam logic [PRIO_W-1:0] SYNC_PRIO_BASE  = 6'h0f;
  localparam logic [PRIO_W-1:0] ASYNC_PRIO_BASE = 6'h01;

  // indices inside the synchronous pending vector (priority 15 at index 0)
  localparam logic [4:0] IDX_VA_FILL = 5'h09;
  localparam logic [4:0] IDX_VA_PROT = 5'h0a;
  localparam logic [4:0] IDX_DSE     = 5'h0e;
  localparam logic [4:0] IDX_BAM     = 5'h11;
  // indices inside the asynchronous pending vector
  localparam logic [2:0] IDX_NMI     = 3'h0;
  localparam logic [2:0] IDX_DAE     = 3'h1;

  // trap classes
  localparam logic [2:0] CLS_MMU     = 3'h0;
  localparam logic [2:0] CLS_PROT    = 3'h1;
  localparam logic [2:0] CLS_CTX     = 3'h3;
  localparam logic [2:0] CLS_ERR     = 3'h4;
  localparam logic [2:0] CLS_ASSERT  = 3'h5;
  localparam logic [2:0] CLS_NMI     = 3'h7;

  // first field is the msb: the lowest priority number sits in bit 0
  typedef struct packed {
    logic break_after_execution;
    logic overflow_assert_trap;
    logic sticky_overflow_trap;
    logic data_sync_bus_error_trap;
    logic peripheral_protection_trap;
    logic write_protection_trap;
    logic read_protection_trap;
    logic data_va_protection_trap;
    logic data_va_fill_trap;
    logic protection_mode_trap;
    logic alignment_trap;
    logic data_address_trap;
    logic context_type_trap;
    logic nesting_error_trap;
    logic call_depth_underflow_trap;
    logic call_depth_overflow_trap;
    logic call_stack_underflow_trap;
    logic free_list_underflow_trap;
  } tpv_sync_t;

  typedef struct packed {
    logic data_integrity_error_trap;
    logic temporal_async_error_trap;
    logic coprocessor_async_error_trap;
    logic data_async_error_trap;
    logic nmi;
  } tpv_async_t;

  // winning trap as presented to the fetch logic
  typedef struct packed {
    logic              valid;
    logic              async;
    logic              debug;
    logic [PRIO_W-1:0] prio;
    logic [2:0]        cls;
    logic [31:0]       vector;
  } tpv_win_t;

  // class of each synchronous pending bit
  function automatic logic [2:0] sync_class(input logic [4:0] idx);
    if (idx <= 5'h05) begin
      sync_class = CLS_CTX;
    end else if (idx == IDX_VA_FILL || idx == IDX_VA_PROT) begin
      sync_class = CLS_MMU;
    end else if (idx < IDX_DSE) begin
      sync_class = CLS_PROT;
    end else if (idx == IDX_DSE) begin
      sync_class = CLS_ERR;
    end else if (idx < IDX_BAM) begin
      sync_class = CLS_ASSERT;
    end else begin
      sync_class = CLS_MMU;
    end
  endfunction : sync_class

  // handler entry: class shifted up and ored into the base
  function automatic logic [31:0] trap_vector(input logic [31:0] base,
                                              input logic [2:0]  cls);
    trap_vector = base | {24'h00_0000, cls, 5'h00};
  endfunction : trap_vector

endpackage : tpv_pkg

// File: tpv_prio_enc.sv
// fixed priority encoder: the lowest set index wins
`timescale 1ns/1ps
`default_nettype none
module tpv_prio_enc #(
  parameter int unsigned N = 18,
  parameter int unsigned W = 5
) (
  input  wire logic [N-1:0] req_i,
  output logic              any_o,
  output logic [W-1:0]      idx_o
);

  always_comb begin
    any_o = 1'b0;
    idx_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        any_o = 1'b1;
        idx_o = W'(i);
      end
    end
  end

endmodule : tpv_prio_enc
`default_nettype wire

// File: tpv_src_model.sv
// pipeline trap source model feeding the pending lanes
`timescale 1ns/1ps
`default_nettype none
module tpv_src_model (
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  input  wire logic [17:0]    old_req_i,
  input  wire logic [17:0]    young_req_i,
  input  wire logic [4:0]     async_req_i,
  input  wire logic           store_req_i,
  input  wire logic           irq_req_i,
  output var tpv_pkg::tpv_sync_t  sync_old_o,
  output var tpv_pkg::tpv_sync_t  sync_young_o,
  output var tpv_pkg::tpv_async_t async_o,
  output logic                store_err_o,
  output logic                irq_o
);
  // a request reaches the lanes one cycle after it is driven, as a retiring stage would
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_old_o   <= '0;
      sync_young_o <= '0;
      async_o      <= '0;
      store_err_o  <= 1'b0;
      irq_o        <= 1'b0;
    end else begin
      sync_old_o   <= old_req_i;
      sync_young_o <= young_req_i;
      async_o      <= async_req_i;
      store_err_o  <= store_req_i;
      irq_o        <= irq_req_i;
    end
  end
endmodule : tpv_src_model
`default_nettype wire

// File: tpv_trap_unit.sv
// trap arbitration, vector formation and error information registers
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE1 - context traps rank 15 to 20, lower number wins
// RULE2 - data memory access traps rank 21 to 29 after context traps
// RULE3 - sticky overflow 30, overflow 31, break after execution 32 last
// RULE4 - va fill and va protection only with mmu present and enabled
// RULE5 - async traps rank nmi, data, coprocessor, temporal, integrity
// RULE6 - store bus errors raise the data async trap, not the sync one
// RULE7 - entry address is class shifted left 5 ored with vector base
// RULE8 - vector entries sit 8 words, 32 bytes, apart
// RULE9 - vector base holds bits 31 to 1, bit 0 reserved as zero
// RULE10 - eight trap classes 0 to 7, one table entry each
// RULE11 - software aligns the table base to at least 256 bytes
// RULE12 - vector base writes only while init end protection is lifted
// RULE13 - program sync error info register at 9200, read only
// RULE14 - data sync error info register at 9010, read only
// RULE15 - data async error info register records the last such error; the code captures it only when no nmi is pending in the same cycle
// RULE16 - data async error info is 32 bits at offset 9018
// RULE17 - async beats sync, sync beats interrupt
// RULE18 - older instruction's trap wins, younger pending traps void
// RULE19 - one winner each cycle with its class and vector to fetch
module tpv_trap_unit (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // wishbone classic slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [31:0]       wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // system controls
  input  wire logic              init_end_unlock_i,
  input  wire logic              mmu_enable_i,
  // pending sources
  input  wire tpv_pkg::tpv_sync_t sync_old_i,
  input  wire tpv_pkg::tpv_sync_t sync_young_i,
  input  wire tpv_pkg::tpv_async_t async_i,
  input  wire logic              store_bus_err_i,
  input  wire logic              irq_req_i,
  // error information sources
  input  wire logic              prog_err_valid_i,
  input  wire logic [31:0]       prog_err_info_i,
  input  wire logic [31:0]       dsync_info_i,
  input  wire logic [31:0]       dasync_info_i,
  // to handler fetch logic
  output tpv_pkg::tpv_win_t      trap_o,
  output logic                   trap_from_old_o,
  output logic                   irq_take_o
);

  // ---------------- register file ----------------
  logic [31:0] vec_base;
  logic [31:0] next_vec_base;
  logic [31:0] psync_info;
  logic [31:0] next_psync_info;
  logic [31:0] dsync_info;
  logic [31:0] next_dsync_info;
  logic [31:0] dasync_info;
  logic [31:0] next_dasync_info;
  logic [31:0] next_wb_dat;
  logic        next_wb_ack;
  logic        bus_req;
  logic        wr_base;

  function automatic logic hit(input logic [31:0] adr,
                               input logic [15:0] off);
    hit = (adr[15:2] == off[15:2]);
  endfunction : hit

  // ---------------- arbitration ----------------
  logic [tpv_pkg::NSYNC-1:0]  old_v;
  logic [tpv_pkg::NSYNC-1:0]  young_v;
  logic [tpv_pkg::NASYNC-1:0] async_v;
  logic                       old_any;
  logic                       young_any;
  logic                       async_any;
  logic [4:0]                 old_idx;
  logic [4:0]                 young_idx;
  logic [2:0]                 async_idx;
  logic [4:0]                 sidx;
  tpv_pkg::tpv_win_t          next_trap;
  logic                       next_from_old;
  logic                       next_irq_take;

  // va traps masked away without an enabled mmu
  function automatic logic [tpv_pkg::NSYNC-1:0] mask_va(
      input logic [tpv_pkg::NSYNC-1:0] v, input logic en);
    mask_va = v;
    mask_va[tpv_pkg::IDX_VA_FILL] = v[tpv_pkg::IDX_VA_FILL] & en; // RULE4
    mask_va[tpv_pkg::IDX_VA_PROT] = v[tpv_pkg::IDX_VA_PROT] & en; // RULE4
  endfunction : mask_va

  always_comb begin
    old_v   = mask_va(sync_old_i, mmu_enable_i);
    young_v = mask_va(sync_young_i, mmu_enable_i);
    async_v = async_i;
    // store errors cannot be tied to the executing load
    async_v[tpv_pkg::IDX_DAE] = async_i.data_async_error_trap |
                                store_bus_err_i; // RULE6
  end

  tpv_prio_enc #(.N(tpv_pkg::NSYNC), .W(5)) u_enc_old (
    .req_i (old_v),
    .any_o (old_any),
    .idx_o (old_idx)
  ); // RULE1 RULE2 RULE3
  tpv_prio_enc #(.N(tpv_pkg::NSYNC), .W(5)) u_enc_young (
    .req_i (young_v),
    .any_o (young_any),
    .idx_o (young_idx)
  );
  tpv_prio_enc #(.N(tpv_pkg::NASYNC), .W(3)) u_enc_async (
    .req_i (async_v),
    .any_o (async_any),
    .idx_o (async_idx)
  ); // RULE5

  always_comb begin
    next_trap     = '0;
    next_from_old = 1'b0;
    next_irq_take = 1'b0;
    sidx          = old_any ? old_idx : young_idx; // RULE18
    if (async_any) begin // RULE17
      next_trap.valid = 1'b1;
      next_trap.async = 1'b1;
      next_trap.prio  = tpv_pkg::ASYNC_PRIO_BASE + {3'h0, async_idx};
      next_trap.cls   = (async_idx == tpv_pkg::IDX_NMI) ?
                        tpv_pkg::CLS_NMI : tpv_pkg::CLS_ERR;
    end else if (old_any || young_any) begin // RULE17
      next_trap.valid = 1'b1;
      next_trap.debug = (sidx == tpv_pkg::IDX_BAM); // RULE3
      next_trap.prio  = tpv_pkg::SYNC_PRIO_BASE + {1'b0, sidx};
      next_trap.cls   = tpv_pkg::sync_class(sidx); // RULE10
      next_from_old   = old_any; // RULE18
    end else begin
      next_irq_take   = irq_req_i; // RULE17
    end
    next_trap.vector  = tpv_pkg::trap_vector(vec_base, // RULE8
                                             next_trap.cls); // RULE7 RULE19
  end

  // ---------------- wishbone slave ----------------
  always_comb begin
    bus_req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wr_base       = bus_req & wb_we_i & hit(wb_adr_i, tpv_pkg::OFF_VEC_BASE);
    next_wb_ack   = bus_req;
    next_wb_dat   = 32'h0000_0000;
    next_vec_base = vec_base;
    if (bus_req && !wb_we_i) begin
      if (hit(wb_adr_i, tpv_pkg::OFF_VEC_BASE)) begin
        next_wb_dat = vec_base;
      end else if (hit(wb_adr_i, tpv_pkg::OFF_PSYNC_INFO)) begin
        next_wb_dat = psync_info; // RULE13
      end else if (hit(wb_adr_i, tpv_pkg::OFF_DSYNC_INFO)) begin
        next_wb_dat = dsync_info; // RULE14
      end else if (hit(wb_adr_i, tpv_pkg::OFF_DASYNC_INFO)) begin
        next_wb_dat = dasync_info; // RULE16
      end
    end
    if (wr_base && init_end_unlock_i) begin // RULE12
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          next_vec_base[8*b +: 8] = wb_dat_i[8*b +: 8];
        end
      end
    end
    next_vec_base[tpv_pkg::VEC_BASE_RES_BIT] = 1'b0; // RULE9
  end

  // ---------------- error information capture ----------------
  always_comb begin
    next_psync_info  = psync_info;
    next_dsync_info  = dsync_info;
    next_dasync_info = dasync_info;
    if (prog_err_valid_i) begin
      next_psync_info = prog_err_info_i; // RULE13
    end
    if (!async_any && (old_any || young_any) &&
        sidx == tpv_pkg::IDX_DSE) begin
      next_dsync_info = dsync_info_i; // RULE14
    end
    if (async_any && async_idx == tpv_pkg::IDX_DAE) begin
      next_dasync_info = dasync_info_i; // RULE15
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vec_base        <= tpv_pkg::VEC_BASE_RST;
      psync_info      <= tpv_pkg::INFO_RST;
      dsync_info      <= tpv_pkg::INFO_RST;
      dasync_info     <= tpv_pkg::INFO_RST;
      wb_dat_o        <= 32'h0000_0000;
      wb_ack_o        <= 1'b0;
      trap_o          <= '0;
      trap_from_old_o <= 1'b0;
      irq_take_o      <= 1'b0;
    end else if (ce_i) begin
      vec_base        <= next_vec_base;
      psync_info      <= next_psync_info;
      dsync_info      <= next_dsync_info;
      dasync_info     <= next_dasync_info;
      wb_dat_o        <= next_wb_dat;
      wb_ack_o        <= next_wb_ack;
      trap_o          <= next_trap;
      trap_from_old_o <= next_from_old;
      irq_take_o      <= next_irq_take;
    end
  end

  // ---------------- assertions ----------------
  a_vector_formula: assert property (@(posedge clk_i) // RULE7
    disable iff (rst_i)
    $past(ce_i) && trap_o.valid |->
      trap_o.vector == ($past(vec_base) | {24'h00_0000, trap_o.cls, 5'h00}))
    else $error("vector not base ored with shifted class");

  a_entry_spacing: assert property (@(posedge clk_i) // RULE8
    disable iff (rst_i)
    $past(ce_i) && trap_o.valid |->
      trap_o.vector[4:0] == $past(vec_base[4:0]))
    else $error("class disturbed the low five vector bits");

  a_async_first: assert property (@(posedge clk_i) // RULE17
    disable iff (rst_i)
    $past(ce_i) && $past(|async_v) |->
      trap_o.async && trap_o.prio <= 6'h05 && !irq_take_o)
    else $error("async trap did not win");

  a_no_va_trap: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
    $past(ce_i) && !$past(mmu_enable_i) |->
      !(trap_o.valid && !trap_o.async &&
        (trap_o.prio == 6'h18 || trap_o.prio == 6'h19)))
    else $error("va trap without enabled mmu");

  a_ctx_top: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
    $past(ce_i) && !$past(|async_v) &&
    $past(sync_old_i.free_list_underflow_trap) |->
      trap_o.prio == 6'h0f && trap_o.cls == tpv_pkg::CLS_CTX)
    else $error("free list underflow not ranked first");

  a_assert_rank: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
    $past(ce_i) && !$past(|async_v) &&
    $past(sync_old_i) == 18'h18000 |->
      trap_o.prio == 6'h1e && trap_o.cls == tpv_pkg::CLS_ASSERT)
    else $error("sticky overflow not ranked 30");

  a_dmem_rank: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
    $past(ce_i) && !$past(|async_v) && $past(old_v[5:0]) == 6'h00 &&
    $past(sync_old_i.alignment_trap) |->
      trap_o.prio == 6'h16 || trap_o.prio == 6'h15)
    else $error("alignment trap mis-ranked");

  a_store_err: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
    $past(ce_i) && $past(store_bus_err_i) && !$past(async_i.nmi) |->
      trap_o.async && trap_o.prio == 6'h02 && trap_o.cls == tpv_pkg::CLS_ERR)
    else $error("store bus error not routed to data async trap");

  a_older_wins: assert property (@(posedge clk_i) disable iff (rst_i) // RULE18
    $past(ce_i) && !$past(|async_v) && $past(|old_v) |->
      trap_from_old_o && trap_o.prio == 6'h0f + {1'b0, $past(old_idx)})
    else $error("younger trap beat older one");

  a_base_locked: assert property (@(posedge clk_i) // RULE12
    disable iff (rst_i)
    $past(ce_i) && $past(wr_base) && !$past(init_end_unlock_i) |->
      vec_base == $past(vec_base))
    else $error("vector base written while protected");

  a_base_bit0: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
    wb_ack_o ##0 $past(hit(wb_adr_i, tpv_pkg::OFF_VEC_BASE)) |->
      !wb_dat_o[0])
    else $error("reserved vector base bit read as one");

  a_one_winner: assert property (@(posedge clk_i) disable iff (rst_i) // RULE19
    $past(ce_i) && $past(old_any | young_any) && !$past(async_any) |->
      ##0 trap_o.valid && !irq_take_o && trap_o.prio >= 6'h0f &&
      trap_o.prio <= 6'h20)
    else $error("no single sync winner presented");

  a_ce_freeze: assert property (@(posedge clk_i) disable iff (rst_i) // RULE19
    !$past(ce_i) |->
      $stable(trap_o) && $stable(irq_take_o) && $stable(vec_base))
    else $error("state moved while the clock enable was low");

  a_irq_last: assert property (@(posedge clk_i) disable iff (rst_i) // RULE17
    $past(ce_i) && $past(irq_req_i) &&
    !$past(async_any | old_any | young_any) |->
      irq_take_o && !trap_o.valid)
    else $error("interrupt not taken with nothing pending");

  a_nmi_top: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
    $past(ce_i) && $past(async_i.nmi) |->
      trap_o.prio == 6'h01 && trap_o.cls == tpv_pkg::CLS_NMI)
    else $error("nmi did not rank first");

  a_dsync_info: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
    $past(ce_i) && !$past(async_any) && $past(old_any | young_any) &&
    $past(sidx) == tpv_pkg::IDX_DSE |->
      dsync_info == $past(dsync_info_i))
    else $error("data sync info not captured on a bus error trap");

endmodule : tpv_trap_unit
`default_nettype wire
